/* File: verilog/uart_global_map.vh */
/*
 Register offsets, field positions, reset values and timing counts for the
 global configuration block of the eight-channel UART.
 Assumes a 32-bit classic Wishbone slave with one register per aligned word.
*/
`ifndef UART_GLOBAL_MAP_VH
`define UART_GLOBAL_MAP_VH

// ****************************************************************
// Register indices (byte address is index times four)
// ****************************************************************
`define IDX_CHANNEL_PENDING_SUMMARY 8'h80
`define IDX_SOURCE_LOCATOR_LOW      8'h81
`define IDX_SOURCE_LOCATOR_MID      8'h82
`define IDX_SOURCE_LOCATOR_HIGH     8'h83
`define IDX_COUNTER_CONTROL         8'h84
`define IDX_COUNTER_RESERVED        8'h85
`define IDX_COUNTER_VALUE_LOW       8'h86
`define IDX_COUNTER_VALUE_HIGH      8'h87
`define IDX_SAMPLING_RATE_SELECT    8'h88
`define IDX_RESERVED_GLOBAL_A       8'h89
`define IDX_CHANNEL_SOFT_RESET      8'h8A
`define IDX_CHANNEL_SLEEP_ENABLE    8'h8B
`define IDX_SILICON_REVISION        8'h8C
`define IDX_DEVICE_IDENTIFICATION   8'h8D
`define IDX_WAKE_CONTROL            8'h8F

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_INT_ENABLE  0
`define CTL_RUN         1
`define CTL_ONE_SHOT    2
`define CTL_EXT_CLOCK   3

// ****************************************************************
// Source codes
// ****************************************************************
`define SRC_NONE        3'h0
`define SRC_RX          3'h1
`define SRC_RX_TIMEOUT  3'h2
`define SRC_TX_READY    3'h3
`define SRC_MODEM       3'h4
`define SRC_TIMER       3'h7

// ****************************************************************
// Reset values, identity and timing
// ****************************************************************
`define RST_BYTE        8'h00
`define RST_COUNT       16'h0000
`define ID_SERIES       4'hA    // Arbitrary series code
`define ID_CHANNELS     4'h8
`define REV_VALUE       8'h05   // Arbitrary revision value
`define WAKE_SETTLE_CLKS 6'h20

`endif

/* File: verilog/pin_sync3.v */
/*
 Three-flop synchroniser with agreement filter for one pin input.
 Assumes the pin is asynchronous to i_sys_clk.
*/
`timescale 1ns/10ps

module pin_sync3 (
   input  wire i_sys_clk,   // System clock
   input  wire i_reset_n,   // Async reset, active low
   input  wire i_pin,       // Raw pin
   output reg  o_level      // Filtered level
);

   reg s1_q;                // First stage, read only by s2
   reg s2_q;                // Second stage
   reg s3_q;                // Third stage

   // ****************************************************************
   // Chain; level changes only when stages two and three agree
   // ****************************************************************
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin  // Agreement filter
            o_level <= s3_q;
         end
      end
   end

endmodule // pin_sync3

/* File: verilog/uart_global_config.v */
/*
 Global configuration and status registers of an eight-channel UART:
 pending summary, source locator, down-counting timer, sampling select,
 soft reset, sleep control with wake-up and identity registers.
 Assumes per-channel cause levels and activity flags come from channel logic
 on the same clock; the external counter clock is an asynchronous pin.
*/
// Functional notes
// - Eight-bit summary, bit N flags channel N
// - Summary clears when channel cause is cleared
// - 24-bit locator, three bits per channel packed
// - Priority 1: receive ready or line error
// - Code 010: receive time-out, priority 2
// - Code 011: transmit ready, priority 3
// - Code 100: modem change or flow character
// - Code 111: timer, channel 0 only
// - 16-bit down counter, internal or pin clock
// - Control bit 0 enables; read clears timer
// - Control bit 1 runs or pauses counter
// - Control bit 2 selects one-shot mode
// - Control bit 3 selects pin clock
// - Value from low and high bytes, reset zero
// - Sampling bit N selects 8X for channel
// - Soft reset bit pulses and self-clears
// - Sleep enabled; enters only without pending interrupt
// - All asleep stops oscillator; wake on activity
// - Wait 32 clocks after wake-up
// - Wake-up interrupt reports no source pending
// - Identification: series nibble, channel count nibble
// - Read-only revision register
// - Interrupt registers read zero after reset
// - Wake interrupt only if enabled and all slept
`timescale 1ns/10ps
`include "uart_global_map.vh"

module uart_global_config (
   input  wire        i_sys_clk,        // System clock, 200 MHz
   input  wire        i_reset_n,        // Async reset, active low
   // Wishbone classic slave
   input  wire        i_wb_cyc,         // Cycle
   input  wire        i_wb_stb,         // Strobe
   input  wire        i_wb_we,          // Write enable
   input  wire [9:0]  i_wb_adr,         // Byte address
   input  wire [3:0]  i_wb_sel,         // Byte lanes
   input  wire [31:0] i_wb_dat,         // Write data
   output reg  [31:0] o_wb_dat,         // Read data
   output reg         o_wb_ack,         // Acknowledge
   // Per-channel cause levels from channel logic
   input  wire [7:0]  i_rx_ready,       // Receive ready or line error
   input  wire [7:0]  i_rx_timeout,     // Receive time-out
   input  wire [7:0]  i_tx_ready,       // Transmit ready
   input  wire [7:0]  i_modem_change,   // Modem or flow character
   input  wire [7:0]  i_chan_activity,  // Receive byte or input change
   input  wire        i_external_counter_clock_pin, // Pin clock
   // Outputs
   output reg  [7:0]  o_sample_8x,      // 8X sampling per channel
   output reg  [7:0]  o_chan_reset,     // One-cycle soft reset pulse
   output reg  [7:0]  o_chan_asleep,    // Channel sleeping
   output reg         o_osc_stop,       // Oscillator shut off
   output reg         o_chan_ready,     // Channels fully operational
   output reg         o_irq             // Any interrupt pending
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [7:0]  ctl_q;          // Counter control bits 3:0 used
   reg  [7:0]  sleep_en_q;     // Sleep enable per channel
   reg  [15:0] preset_q;       // Programmed count
   reg  [15:0] count_q;        // Running count
   reg         tmr_pend_q;     // Timer interrupt latched
   reg         wake_en_q;      // Wake-up interrupt enable
   reg         wake_pend_q;    // Wake-up interrupt latched
   reg         full_sleep_q;   // All eight asleep
   reg  [5:0]  settle_q;       // Post-wake settle counter
   reg         ext_prev_q;     // Previous filtered pin level
   reg  [7:0]  rd_data_d;      // Read mux
   reg  [2:0]  src_d [0:7];    // Per-channel code
   wire [23:0] locator;        // Packed codes
   wire [7:0]  pending;        // Summary
   wire        ext_level;      // Filtered pin clock
   wire        access;         // New bus request
   wire        wr;             // Write this cycle
   wire        rd;             // Read this cycle
   wire [7:0]  idx;            // Register index
   wire        tick;           // Counter step enable
   wire        ctl_read;       // Control register read
   wire        any_activity;   // Wake source
   wire        one_shot_done;  // One-shot time-out this cycle

   assign access = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr     = access & i_wb_we & i_wb_sel[0];
   assign rd     = access & ~i_wb_we;
   assign idx    = i_wb_adr[9:2];
   assign ctl_read = rd & (idx == `IDX_COUNTER_CONTROL);
   assign any_activity = |i_chan_activity;

   // ****************************************************************
   // Pin clock synchroniser
   // ****************************************************************
   pin_sync3 u_ext_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_pin     (i_external_counter_clock_pin),
      .o_level   (ext_level)
   );

   // Internal clock steps every cycle; pin clock on its rising edge
   assign tick = ctl_q[`CTL_EXT_CLOCK] ? (ext_level & ~ext_prev_q) : 1'b1;

   // ****************************************************************
   // Source encoding, highest priority first
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_src
         always @* begin
            if (i_rx_ready[g]) begin
               src_d[g] = `SRC_RX;
            end else if (i_rx_timeout[g]) begin
               src_d[g] = `SRC_RX_TIMEOUT;
            end else if (i_tx_ready[g]) begin
               src_d[g] = `SRC_TX_READY;
            end else if (i_modem_change[g]) begin
               src_d[g] = `SRC_MODEM;
            end else if ((g == 0) && tmr_pend_q) begin
               src_d[g] = `SRC_TIMER;
            end else begin
               src_d[g] = `SRC_NONE;                // Wake-up shows as none
            end
         end
         // Channel clears when its cause is cleared upstream
         assign pending[g] = (src_d[g] != `SRC_NONE);
         assign locator[3*g +: 3] = src_d[g];
      end
   endgenerate

   // ****************************************************************
   // Read multiplexer; reserved bits and unmapped read zero
   // ****************************************************************
   always @* begin
      case (idx)
         `IDX_CHANNEL_PENDING_SUMMARY: rd_data_d = pending;
         `IDX_SOURCE_LOCATOR_LOW:      rd_data_d = locator[7:0];
         `IDX_SOURCE_LOCATOR_MID:      rd_data_d = locator[15:8];
         `IDX_SOURCE_LOCATOR_HIGH:     rd_data_d = locator[23:16];
         `IDX_COUNTER_CONTROL:         rd_data_d = {4'h0, ctl_q[3:0]};
         `IDX_COUNTER_VALUE_LOW:       rd_data_d = preset_q[7:0];
         `IDX_COUNTER_VALUE_HIGH:      rd_data_d = preset_q[15:8];
         `IDX_SAMPLING_RATE_SELECT:    rd_data_d = o_sample_8x;
         `IDX_CHANNEL_SLEEP_ENABLE:    rd_data_d = sleep_en_q;
         `IDX_SILICON_REVISION:        rd_data_d = `REV_VALUE;
         `IDX_DEVICE_IDENTIFICATION:   rd_data_d = {`ID_SERIES, `ID_CHANNELS};
         `IDX_WAKE_CONTROL:            rd_data_d = {6'h00, wake_pend_q, wake_en_q};
         default:                      rd_data_d = `RST_BYTE;
      endcase
   end

   // ****************************************************************
   // Bus answer: ack one cycle after request, dropped the next
   // ****************************************************************
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= access;
         if (rd) begin
            o_wb_dat <= {24'h000000, rd_data_d};
         end
      end
   end

   // ****************************************************************
   // Writable registers and soft reset pulse
   // ****************************************************************
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_q        <= `RST_BYTE;
         preset_q     <= `RST_COUNT;
         o_sample_8x  <= `RST_BYTE;
         sleep_en_q   <= `RST_BYTE;
         o_chan_reset <= `RST_BYTE;
         wake_en_q    <= 1'b0;
      end else begin
         // Self-clearing: pulse lasts one cycle only
         o_chan_reset <= `RST_BYTE;
         if (wr) begin
            case (idx)
               `IDX_COUNTER_CONTROL:      ctl_q <= {4'h0, i_wb_dat[3:0]};
               `IDX_COUNTER_VALUE_LOW:    preset_q[7:0] <= i_wb_dat[7:0];
               `IDX_COUNTER_VALUE_HIGH:   preset_q[15:8] <= i_wb_dat[7:0];
               `IDX_SAMPLING_RATE_SELECT: o_sample_8x <= i_wb_dat[7:0];
               `IDX_CHANNEL_SOFT_RESET:   o_chan_reset <= i_wb_dat[7:0];
               `IDX_CHANNEL_SLEEP_ENABLE: sleep_en_q <= i_wb_dat[7:0];
               `IDX_WAKE_CONTROL:         wake_en_q <= i_wb_dat[0];
               default:                   ctl_q <= ctl_q;
            endcase
         end
         // One-shot stops itself; a host write to control in that cycle wins
         if (one_shot_done && !(wr && (idx == `IDX_COUNTER_CONTROL))) begin
            ctl_q[`CTL_RUN] <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Down counter; time-out at zero, reload or stop
   // ****************************************************************
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_q    <= `RST_COUNT;
         tmr_pend_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_level;
         if (wr && (idx == `IDX_COUNTER_CONTROL) && i_wb_dat[`CTL_RUN] && !ctl_q[`CTL_RUN]) begin
            count_q <= preset_q;           // Start loads the preset
         end else if (ctl_q[`CTL_RUN] && tick) begin   // Paused keeps count
            if (count_q == 16'h0000) begin
               count_q <= preset_q;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
         // One-shot stop clears run in the register process
         // Set wins over the clearing read
         if (ctl_q[`CTL_RUN] && tick && (count_q == 16'h0000) && ctl_q[`CTL_INT_ENABLE]) begin
            tmr_pend_q <= 1'b1;
         end else if (ctl_read) begin
            tmr_pend_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Sleep, oscillator stop, wake-up and settle
   // ****************************************************************
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_chan_asleep <= `RST_BYTE;
         o_osc_stop    <= 1'b0;
         full_sleep_q  <= 1'b0;
         wake_pend_q   <= 1'b0;
         settle_q      <= 6'h00;
         o_chan_ready  <= 1'b1;
         o_irq         <= 1'b0;
      end else begin
         // Channel sleeps only while enabled and not pending
         // Wake interrupt counts as pending: no re-sleep until it is read
         o_chan_asleep <= sleep_en_q & ~pending & ~{8{wake_pend_q}};
         if (full_sleep_q && any_activity) begin
            // Wake: restart oscillator, report with no source
            full_sleep_q <= 1'b0;
            o_osc_stop   <= 1'b0;
            settle_q     <= `WAKE_SETTLE_CLKS;
            o_chan_ready <= 1'b0;
            if (wake_en_q) begin
               wake_pend_q <= 1'b1;
            end
         end else begin
            if ((o_chan_asleep == 8'hFF) && (settle_q == 6'h00) && !any_activity) begin
               full_sleep_q <= 1'b1;
               o_osc_stop   <= 1'b1;
            end
            if (rd && (idx == `IDX_WAKE_CONTROL)) begin
               wake_pend_q <= 1'b0;
            end
            if (settle_q != 6'h00) begin
               settle_q <= settle_q - 6'h01;
               o_chan_ready <= (settle_q == 6'h01);
            end
         end
         o_irq <= (|pending) | wake_pend_q;   // Zero after reset
      end
   end

   // One-shot: drop run after the time-out tick
   assign one_shot_done = ctl_q[`CTL_ONE_SHOT] & ctl_q[`CTL_RUN] & tick & (count_q == 16'h0000);

endmodule // uart_global_config

/* File: testbench/uart_global_config_assertions.sv */
/*
 Checker for the global configuration block, bound to its top module.
 Assumes one clock domain, async active-low reset, map header on include path.
*/
`timescale 1ns/10ps
`include "uart_global_map.vh"

module uart_global_checker (
   input wire        i_sys_clk,      // System clock
   input wire        i_reset_n,      // Async reset, active low
   input wire        i_wb_we,        // Write enable
   input wire [9:0]  i_wb_adr,       // Byte address
   input wire [31:0] i_wb_dat,       // Write data
   input wire [31:0] o_wb_dat,       // Read data
   input wire        o_wb_ack,       // Acknowledge
   input wire [7:0]  i_rx_ready,     // Cause levels
   input wire [7:0]  i_rx_timeout,
   input wire [7:0]  i_tx_ready,
   input wire [7:0]  i_modem_change,
   input wire [7:0]  o_sample_8x,    // Sampling select
   input wire [7:0]  o_chan_reset,   // Soft reset pulse
   input wire [7:0]  o_chan_asleep,  // Sleep state
   input wire        o_osc_stop,     // Oscillator off
   input wire        o_chan_ready,   // Channels usable
   input wire        o_irq           // Interrupt out
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Any cause per channel, the register index, and an acknowledged read
   wire [7:0] cause = i_rx_ready | i_rx_timeout | i_tx_ready | i_modem_change;
   wire [7:0] idx   = i_wb_adr[9:2];
   wire       rd_ok = o_wb_ack && !i_wb_we;

   property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_ident; rd_ok && idx == `IDX_DEVICE_IDENTIFICATION |-> o_wb_dat[7:0] == {`ID_SERIES, `ID_CHANNELS}; endproperty
   a_ident: assert property (p_ident) else $error("identification value wrong");
   property p_rev; rd_ok && idx == `IDX_SILICON_REVISION |-> o_wb_dat[7:0] == `REV_VALUE; endproperty
   a_rev: assert property (p_rev) else $error("revision value wrong");
   property p_rsvd; rd_ok && idx == `IDX_COUNTER_CONTROL |-> o_wb_dat[7:4] == 4'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("control upper bits not zero");
   property p_sample; o_wb_ack && i_wb_we && idx == `IDX_SAMPLING_RATE_SELECT |=> o_sample_8x == $past(i_wb_dat[7:0]); endproperty
   a_sample: assert property (p_sample) else $error("sampling select not written");
   property p_rst_pulse; o_chan_reset != 8'h00 |=> o_chan_reset == 8'h00; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("soft reset did not self clear");
   property p_osc_all; o_osc_stop |-> o_chan_asleep == 8'hFF; endproperty
   a_osc_all: assert property (p_osc_all) else $error("oscillator stopped while a channel awake");
   property p_sleep_entry; ((o_chan_asleep & ~$past(o_chan_asleep)) & $past(cause) & $past(cause, 2)) == 8'h00; endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("channel slept with a pending cause");
   property p_irq_cause; (cause != 8'h00) [*3] |-> o_irq; endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("pending cause without interrupt");
   // Settle time: thirty cycles low, then ready within forty
   property p_ready_min; $fell(o_osc_stop) |=> (!o_chan_ready) [*8] ##1 (!o_chan_ready) [*8] ##1 (!o_chan_ready) [*8] ##1 (!o_chan_ready) [*6]; endproperty
   a_ready_min: assert property (p_ready_min) else $error("ready too soon after wake");
   property p_ready_max; $fell(o_osc_stop) |-> ##[1:40] o_chan_ready; endproperty
   a_ready_max: assert property (p_ready_max) else $error("ready too late after wake");
endmodule // uart_global_checker

bind uart_global_config uart_global_checker uart_global_checker_inst (.i_sys_clk, .i_reset_n, .i_wb_we,
   .i_wb_adr, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_rx_ready, .i_rx_timeout, .i_tx_ready, .i_modem_change,
   .o_sample_8x, .o_chan_reset, .o_chan_asleep, .o_osc_stop, .o_chan_ready, .o_irq);

/* File: testbench/wb_host_model.sv */
/*
 Host processor model: classic Wishbone master doing single cycles.
 Assumes the slave answers with a one-cycle ack; the bench cuts hangs.
*/
`timescale 1ns/10ps

module wb_host_model (
   input  wire        i_sys_clk,  // System clock
   input  wire        i_wb_ack,   // Acknowledge
   input  wire [31:0] i_wb_dat,   // Read data
   output reg         o_wb_cyc,   // Cycle
   output reg         o_wb_stb,   // Strobe
   output reg         o_wb_we,    // Write enable
   output reg  [9:0]  o_wb_adr,   // Byte address
   output reg  [3:0]  o_wb_sel,   // Byte lanes
   output reg  [31:0] o_wb_dat    // Write data
);
   // Bus idle at time zero
   initial begin
      {o_wb_cyc, o_wb_stb, o_wb_we, o_wb_sel} = 7'h00;
      o_wb_adr = 10'h000;
      o_wb_dat = 32'h00000000;
   end
   // One cycle, held until ack is sampled high; no fixed latency assumed
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_sys_clk);
      {o_wb_cyc, o_wb_stb, o_wb_we, o_wb_sel} <= {2'b11, we, 4'hF};
      o_wb_adr <= {idx, 2'b00};
      o_wb_dat <= {24'h000000, d};
      @(posedge i_sys_clk);
      while (i_wb_ack !== 1'b1) @(posedge i_sys_clk);
      q = i_wb_dat[7:0];
      // Released address and data flip so a stale value is never mistaken for data
      {o_wb_cyc, o_wb_stb, o_wb_we, o_wb_sel} <= 7'h00;
      o_wb_adr <= ~{idx, 2'b00};
      o_wb_dat <= ~{24'h000000, d};
   endtask
endmodule // wb_host_model

/* File: testbench/octal_uart_global_config_tb.sv */
/*
 Self-checking bench: register map, locator codes, timer, sampling,
 soft reset and sleep with wake-up. Assumes the host model drives the bus.
*/
`timescale 1ns/10ps
`include "uart_global_map.vh"

module octal_uart_global_config_tb;
   localparam [7:0]  SUM = `IDX_CHANNEL_PENDING_SUMMARY, LOC = `IDX_SOURCE_LOCATOR_LOW, CTL = `IDX_COUNTER_CONTROL;
   localparam [7:0]  VLO = `IDX_COUNTER_VALUE_LOW, VHI = `IDX_COUNTER_VALUE_HIGH, WAKE = `IDX_WAKE_CONTROL;
   localparam [23:0] LOC_EXP = {3'h0, 3'h3, 3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h1}; // Ch7 down to ch0
   reg         i_sys_clk = 1'b0;    // 200 MHz
   reg         i_reset_n = 1'b0;    // Low for 4 cycles
   reg  [7:0]  rx_rdy = 8'h00;      // Cause levels
   reg  [7:0]  rx_to = 8'h00;
   reg  [7:0]  tx_rdy = 8'h00;
   reg  [7:0]  mdm = 8'h00;
   reg  [7:0]  act = 8'h00;         // Wake activity
   reg         ext_pin = 1'b0;      // Counter pin clock
   reg  [7:0]  rst_seen = 8'h00;    // Soft reset bits seen
   reg  [7:0]  rst_pulses = 8'h00;  // Cycles with a pulse
   reg  [7:0]  q;                   // Last read byte
   integer     mismatches = 0;
   integer     samples_checked = 0;
   integer     i;
   wire        cyc, stb, we, ack, osc, rdy, irq;
   wire [9:0]  adr;
   wire [3:0]  sel;
   wire [31:0] wdat, rdat;
   wire [7:0]  s8x, crst, asleep;

   uart_global_config uart_global_config_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_rx_ready(rx_rdy), .i_rx_timeout(rx_to), .i_tx_ready(tx_rdy), .i_modem_change(mdm),
      .i_chan_activity(act), .i_external_counter_clock_pin(ext_pin), .o_sample_8x(s8x), .o_chan_reset(crst),
      .o_chan_asleep(asleep), .o_osc_stop(osc), .o_chan_ready(rdy), .o_irq(irq));
   wb_host_model wb_host_model_inst (.i_sys_clk(i_sys_clk), .i_wb_ack(ack), .i_wb_dat(rdat), .o_wb_cyc(cyc),
      .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));

   always #2.5 i_sys_clk = ~i_sys_clk;
   // Collect soft reset pulses; a stretched pulse shows as a count above one
   always @(posedge i_sys_clk) begin
      if (crst != 8'h00) begin
         rst_seen <= rst_seen | crst;
         rst_pulses <= rst_pulses + 8'h01;
      end
   end
   // Whole run is about 1100 cycles; this only catches a hung bus
   initial begin
      #50000;
      mismatches = mismatches + 1;
      close_out;
   end

   task chk(input [7:0] got, input [7:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      wb_host_model_inst.xfer(1'b1, a, d, q);
   endtask
   task rc(input [7:0] a, input [7:0] e);
      wb_host_model_inst.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      // Reset values from 0x80 to 0x8D except soft reset, then unmapped and read-only places
      for (i = 8'h80; i < 8'h8E; i = i + 1) begin
         if (i != 8'h8A) rc(i[7:0], i == 8'h8C ? `REV_VALUE : i == 8'h8D ? {`ID_SERIES, `ID_CHANNELS} : 8'h00);
      end
      chk({5'h00, osc, rdy, irq}, 8'h02);
      rc(8'h00, 8'h00);
      wr(8'h8D, 8'h00);
      rc(8'h8D, {`ID_SERIES, `ID_CHANNELS});
      // Source codes 000 to 100 at once, mixed causes resolved by priority
      {rx_rdy, rx_to, tx_rdy, mdm} <= {8'h11, 8'h22, 8'h54, 8'h68};
      repeat (4) @(posedge i_sys_clk);
      rc(SUM, 8'h7F);
      for (i = 0; i < 3; i = i + 1) rc(LOC + i[7:0], LOC_EXP[8 * i +: 8]);
      {rx_rdy, rx_to, tx_rdy, mdm} <= 32'h00000000;
      repeat (4) @(posedge i_sys_clk);
      rc(SUM, 8'h00);
      rc(LOC, 8'h00);
      // Timer: preset 64, periodic with interrupt
      wr(VLO, 8'h40);
      wr(VHI, 8'h12);
      rc(VHI, 8'h12);
      wr(VHI, 8'h00);
      wr(CTL, 8'hF0);
      rc(CTL, 8'h00);
      wr(CTL, 8'h03);
      repeat (30) @(posedge i_sys_clk);
      rc(LOC, 8'h00);
      repeat (45) @(posedge i_sys_clk);
      rc(SUM, 8'h01);
      rc(LOC, 8'h07);
      rc(CTL, 8'h03);
      rc(LOC, 8'h00);
      repeat (60) @(posedge i_sys_clk);
      rc(LOC, 8'h07);
      wr(CTL, 8'h01);
      rc(CTL, 8'h01);
      repeat (150) @(posedge i_sys_clk);
      rc(LOC, 8'h00);
      wr(CTL, 8'h02);
      repeat (150) @(posedge i_sys_clk);
      rc(LOC, 8'h00);
      // One-shot fires once, then stays quiet
      wr(CTL, 8'h00);
      wr(CTL, 8'h07);
      repeat (75) @(posedge i_sys_clk);
      rc(LOC, 8'h07);
      wb_host_model_inst.xfer(1'b0, CTL, 8'h00, q);
      repeat (140) @(posedge i_sys_clk);
      rc(LOC, 8'h00);
      // Pin clock: nothing while the pin is still, time-out once it toggles
      wr(CTL, 8'h00);
      wr(VLO, 8'h03);
      rc(VLO, 8'h03);
      wr(CTL, 8'h0B);
      repeat (60) @(posedge i_sys_clk);
      rc(LOC, 8'h00);
      repeat (16) begin
         repeat (4) @(posedge i_sys_clk);
         ext_pin <= ~ext_pin;
      end
      repeat (8) @(posedge i_sys_clk);
      rc(LOC, 8'h07);
      wr(CTL, 8'h00);
      wb_host_model_inst.xfer(1'b0, CTL, 8'h00, q);
      // Sampling select and soft reset
      wr(`IDX_SAMPLING_RATE_SELECT, 8'hA5);
      chk(s8x, 8'hA5);
      rc(`IDX_SAMPLING_RATE_SELECT, 8'hA5);
      wr(`IDX_CHANNEL_SOFT_RESET, 8'h81);
      repeat (3) @(posedge i_sys_clk);
      chk(rst_seen, 8'h81);
      chk(rst_pulses, 8'h01);
      // Sleep held off by a pending channel, then full sleep and wake-up
      wr(WAKE, 8'h01);
      tx_rdy <= 8'h04;
      wr(`IDX_CHANNEL_SLEEP_ENABLE, 8'hFF);
      repeat (10) @(posedge i_sys_clk);
      chk({osc, asleep[6:0]}, 8'h7B);
      rc(`IDX_CHANNEL_SLEEP_ENABLE, 8'hFF);
      tx_rdy <= 8'h00;
      repeat (10) @(posedge i_sys_clk);
      chk(asleep, 8'hFF);
      chk({7'h00, osc}, 8'h01);
      act <= 8'h20;
      repeat (3) @(posedge i_sys_clk);
      act <= 8'h00;
      repeat (10) @(posedge i_sys_clk);
      chk({6'h00, osc, rdy}, 8'h00);
      repeat (40) @(posedge i_sys_clk);
      chk({6'h00, rdy, irq}, 8'h03);
      wr(`IDX_CHANNEL_SLEEP_ENABLE, 8'h00);
      rc(LOC, 8'h00);
      rc(WAKE, 8'h03);
      @(posedge i_sys_clk); // irq is registered one cycle after the clearing read
      chk({7'h00, irq}, 8'h00);
      close_out;
   end
endmodule // octal_uart_global_config_tb
